// ==== hdl/ppc_pkg.sv ====
// Shared constants, register map and carrier types of the power pulse channel
package ppc_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CNT_W = 14;
  localparam int FINE_W = 4;
  localparam int EV_W = CNT_W + FINE_W;
  localparam int DUTY_W = 24;
  localparam int ERR_W = 9;
  localparam int ADJ_W = 16;
  localparam int DAC_W = 14;
  localparam int DAC_OUT_W = 10;
  localparam int RAW_W = 6;
  localparam int DIV_W = 8;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 21;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_EVENT1 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_EVENT2 = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_EVENT3 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_EVENT4 = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_PHASE = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_THR = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_DEAD = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_ADJ_A = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_ADJ_B = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_DAC = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_ERROR = 8'h38;

  // ****************************************************************
  // Control field positions and reset values
  // ****************************************************************
  localparam int CB_EN = 0;
  localparam int CB_POL_A = 1;
  localparam int CB_POL_B = 2;
  localparam int CB_CLOSED = 3;
  localparam int CB_OS = 4;
  localparam int CB_SYNC_EN = 6;
  localparam int CB_DIV = 8;
  localparam int CB_FE_INV = 16;
  localparam int CB_FE_ABS = 17;
  localparam int CB_FE_AUTO = 18;
  localparam int CB_FE_GAIN = 19;
  localparam logic [CTRL_W-1:0] CTRL_RST = 21'h000000;
  localparam logic [CNT_W-1:0] PERIOD_RST = 14'h00ff;
  localparam logic [1:0] GAIN_MAX = 2'h3;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } ppc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppc_apb_rsp_t;

  typedef struct packed {
    logic done;
    logic [ERR_W-1:0] code;
  } ppc_conv_t;

  typedef struct packed {
    logic invert;
    logic absolute;
    logic auto_gain;
    logic [1:0] gain;
    logic [DAC_W-1:0] dac;
  } ppc_fe_cfg_t;

  typedef enum logic [3:0] {
    R_CTRL, R_PERIOD, R_EVENT1, R_EVENT2, R_EVENT3, R_EVENT4, R_PHASE, R_SAMPLE,
    R_SYNC_THR, R_DEAD, R_ADJ_A, R_ADJ_B, R_DAC, R_STATUS, R_ERROR, R_NONE
  } ppc_reg_t;

  typedef enum logic {FE_IDLE, FE_CONV} ppc_fe_state_t;

endpackage : ppc_pkg

// ==== hdl/ppc_front_end.sv ====
// Error converter control: sample request, gain scaling, dithered set point
`timescale 1ns/1ps
module ppc_front_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_req,
  input wire ppc_pkg::ppc_conv_t conv,
  input wire ppc_pkg::ppc_fe_cfg_t cfg,
  output logic conv_start,
  output logic [ppc_pkg::ERR_W-1:0] err_out,
  output logic strobe,
  output logic [1:0] gain_cur,
  output logic [ppc_pkg::DAC_OUT_W-1:0] dac_code
);
  import ppc_pkg::*;

  typedef struct packed {
    ppc_fe_state_t st;
    logic conv_start;
    logic strobe;
    logic [ERR_W-1:0] err;
    logic [1:0] gain;
    logic [FINE_W-1:0] dither;
    logic [DAC_OUT_W-1:0] dac_code;
  } ppc_fe_st_t;

  ppc_fe_st_t s_reg, s_next;

  assign conv_start = s_reg.conv_start;
  assign strobe = s_reg.strobe;
  assign err_out = s_reg.err;
  assign gain_cur = s_reg.gain;
  assign dac_code = s_reg.dac_code;

  // Next state: one conversion per request, result scaled then handed on
  always_comb begin
    logic signed [ERR_W-1:0] code;
    logic signed [RAW_W-1:0] raw;
    logic signed [ERR_W+2:0] val;
    logic clipped;
    logic [1:0] g;
    code = $signed(conv.code);
    clipped = (code > 9'sd31) || (code < -9'sd32);
    raw = clipped ? (code[ERR_W-1] ? -6'sd32 : 6'sd31) : code[RAW_W-1:0];
    g = cfg.auto_gain ? s_reg.gain : cfg.gain;
    val = 12'(raw) <<< g;
    s_next = s_reg;
    s_next.conv_start = 1'b0;
    s_next.strobe = 1'b0;
    // Ten bit set point with dither
    s_next.dac_code = (cfg.dac[DAC_W-1:FINE_W] == '1) ? cfg.dac[DAC_W-1:FINE_W] :
      cfg.dac[DAC_W-1:FINE_W] + DAC_OUT_W'(s_reg.dither < cfg.dac[FINE_W-1:0]);
    case (s_reg.st)
      FE_IDLE: begin
        if (sample_req) begin
          s_next.conv_start = 1'b1;
          s_next.dither = s_reg.dither + 4'h1;
          s_next.st = FE_CONV;
        end
      end
      FE_CONV: begin
        if (conv.done) begin
          if (cfg.invert) val = -val;
          if (cfg.absolute) val = val + 12'($unsigned(s_reg.dac_code));
          if (val > 12'sd255) val = 12'sd255;
          else if (val < -12'sd256) val = -12'sd256;
          s_next.err = val[ERR_W-1:0];
          s_next.strobe = 1'b1;
          s_next.st = FE_IDLE;
          // Automatic gain keeps finest fitting step
          if (cfg.auto_gain && clipped && s_reg.gain != GAIN_MAX) begin
            s_next.gain = s_reg.gain + 2'h1;
          end else if (cfg.auto_gain && !clipped && code < 9'sd16 && code > -9'sd16 &&
                       s_reg.gain != 2'h0) begin
            s_next.gain = s_reg.gain - 2'h1;
          end else if (!cfg.auto_gain) begin
            // Manual step of 1, 2, 4 or 8
            s_next.gain = cfg.gain;
          end
        end
      end
      default: s_next.st = FE_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Conversion result leads to strobe next cycle
  chk_strobe_after_done: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == FE_CONV && conv.done |=> strobe && s_reg.st == FE_IDLE)
    else $error("filter strobe missing after conversion");
  // Request in idle starts one conversion
  chk_start_on_req: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == FE_IDLE && sample_req |=> conv_start ##1 !conv_start)
    else $error("conversion start not a single pulse");

endmodule : ppc_front_end

// ==== hdl/ppc_channel.sv ====
// Power pulse channel: time base, edge events, sync, sampling and APB registers
`timescale 1ns/1ps
// Functional notes
// - Two outputs A and B, one period
// - Q23 filter duty sets on time
// - Edges placed in quarter nanosecond steps
// - Sync input resets ramp timer
// - Sync output when timer crosses threshold
// - Own fourteen bit configurable time base
// - Period write shadowed until period end
// - Events one to four place edges
// - Phase offset for interleaved operation
// - Programmable sample request point
// - Capture code then strobe the filter
// - Nine bit signed error, mV scaled
// - Step size one, two, four, eight
// - Front end auto gain selection
// - Ten bit DAC plus dither
// - Error inversion and absolute mode
// - Dead time between A and B
// - Signed cycle adjust, 32768 fine steps
// - Per output polarity selection
// - Events for interrupt and converter start
// - Interrupt every N frames, fault, mode
// - Events 2-4 have fine low nibble
// - Trigger count match starts conversion
// - Oversampling one, two, four, eight
module ppc_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire ppc_pkg::ppc_apb_req_t apb_req,
  output ppc_pkg::ppc_apb_rsp_t apb_rsp,
  input wire logic sync_in,
  input wire logic fault_in,
  input wire logic [ppc_pkg::DUTY_W-1:0] duty,
  input wire logic duty_valid,
  input wire ppc_pkg::ppc_conv_t conv,
  output logic conv_start,
  output logic [ppc_pkg::ERR_W-1:0] filter_err,
  output logic filter_strobe,
  output logic [ppc_pkg::DAC_OUT_W-1:0] dac_code,
  output logic out_a,
  output logic out_b,
  output logic [ppc_pkg::FINE_W-1:0] a_fine,
  output logic [ppc_pkg::FINE_W-1:0] b_fine,
  output logic sync_out,
  output logic irq_out,
  output logic general_converter_trig
);
  import ppc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] period_sh;
    logic [CNT_W-1:0] ev1;
    logic [EV_W-1:0] ev2;
    logic [EV_W-1:0] ev3;
    logic [EV_W-1:0] ev4;
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] strig;
    logic [CNT_W-1:0] sthr;
    logic [CNT_W-1:0] dead;
    logic [ADJ_W-1:0] adj_a;
    logic [ADJ_W-1:0] adj_b;
    logic [DAC_W-1:0] dac;
    logic [DUTY_W-1:0] duty_q;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] os_cnt;
    logic [3:0] os_left;
    logic [DIV_W-1:0] frame_cnt;
    logic [CNT_W-1:0] dead_cnt;
    logic a_raw;
    logic b_raw;
    logic a_q;
    logic b_q;
    logic [FINE_W-1:0] a_fine;
    logic [FINE_W-1:0] b_fine;
    logic out_a;
    logic out_b;
    logic sync_out;
    logic irq;
    logic adc_trig;
    logic sample_req;
    logic fault_d;
    logic closed_d;
    ppc_apb_rsp_t rsp;
  } ppc_ch_st_t;

  ppc_ch_st_t s_reg, s_next;
  logic [ERR_W-1:0] fe_err;
  logic [1:0] fe_gain;
  logic [3:0] hit;
  logic [EV_W-1:0] ev_at [4];
  logic [EV_W-1:0] a_fall;
  logic [EV_W-1:0] b_fall;
  logic [EV_W-1:0] e2_eff;
  logic [EV_W-1:0] on_time;
  logic [40:0] prod;
  logic [EV_W:0] e2_sum;
  logic en;
  ppc_fe_cfg_t fe_cfg;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Address decode, shared by the read and the write path
  function automatic ppc_reg_t ppc_decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_CTRL) return R_CTRL;
    else if (a == ADDR_PERIOD) return R_PERIOD;
    else if (a == ADDR_EVENT1) return R_EVENT1;
    else if (a == ADDR_EVENT2) return R_EVENT2;
    else if (a == ADDR_EVENT3) return R_EVENT3;
    else if (a == ADDR_EVENT4) return R_EVENT4;
    else if (a == ADDR_PHASE) return R_PHASE;
    else if (a == ADDR_SAMPLE) return R_SAMPLE;
    else if (a == ADDR_SYNC_THR) return R_SYNC_THR;
    else if (a == ADDR_DEAD) return R_DEAD;
    else if (a == ADDR_ADJ_A) return R_ADJ_A;
    else if (a == ADDR_ADJ_B) return R_ADJ_B;
    else if (a == ADDR_DAC) return R_DAC;
    else if (a == ADDR_STATUS) return R_STATUS;
    else if (a == ADDR_ERROR) return R_ERROR;
    else return R_NONE;
  endfunction : ppc_decode

  // Add a signed fine-step adjust to an event, clamped to the event range
  function automatic logic [EV_W-1:0] ppc_adj_event(input logic [EV_W-1:0] ev,
                                                   input logic [ADJ_W-1:0] adj);
    logic signed [EV_W+1:0] sum;
    sum = $signed({2'b00, ev}) + $signed({{(EV_W+2-ADJ_W){adj[ADJ_W-1]}}, adj});
    if (sum < 0) return '0;
    else if (sum[EV_W]) return '1;
    else return sum[EV_W-1:0];
  endfunction : ppc_adj_event

  assign en = s_reg.ctrl[CB_EN];

  // Q23 duty times period in fine steps; negative duty gives no pulse
  assign prod = 41'(s_reg.duty_q[DUTY_W-2:0]) * 41'({s_reg.period, {FINE_W{1'b0}}});
  assign on_time = s_reg.duty_q[DUTY_W-1] ? '0 : prod[40:23];
  assign e2_sum = {1'b0, s_reg.ev1, {FINE_W{1'b0}}} + {1'b0, on_time};
  assign e2_eff = !s_reg.ctrl[CB_CLOSED] ? s_reg.ev2 : (e2_sum[EV_W] ? '1 : e2_sum[EV_W-1:0]);

  // Cycle adjust on both falling events
  assign a_fall = ppc_adj_event(e2_eff, s_reg.adj_a);
  assign b_fall = ppc_adj_event(s_reg.ev4, s_reg.adj_b);

  // Events 2-4 keep the fine nibble; event 1 is whole counts
  assign ev_at[0] = {s_reg.ev1, {FINE_W{1'b0}}};
  assign ev_at[1] = a_fall;
  assign ev_at[2] = s_reg.ev3;
  assign ev_at[3] = b_fall;

  // One comparator per event against the whole-count part
  for (genvar i = 0; i < 4; i++) begin : g_hit
    assign hit[i] = en && (s_reg.cnt == ev_at[i][EV_W-1:FINE_W]);
  end

  assign fe_cfg = '{invert: s_reg.ctrl[CB_FE_INV], absolute: s_reg.ctrl[CB_FE_ABS],
                    auto_gain: s_reg.ctrl[CB_FE_AUTO],
                    gain: s_reg.ctrl[CB_FE_GAIN +: 2], dac: s_reg.dac};

  // Front end 0, with auto gain available
  ppc_front_end u_fe (
    .pclk(pclk),
    .presetn(presetn),
    .sample_req(s_reg.sample_req),
    .conv(conv),
    .cfg(fe_cfg),
    .conv_start(conv_start),
    .err_out(fe_err),
    .strobe(filter_strobe),
    .gain_cur(fe_gain),
    .dac_code(dac_code)
  );

  assign filter_err = fe_err;
  assign apb_rsp = s_reg.rsp;
  assign out_a = s_reg.out_a;
  assign out_b = s_reg.out_b;
  assign a_fine = s_reg.a_fine;
  assign b_fine = s_reg.b_fine;
  assign sync_out = s_reg.sync_out;
  assign irq_out = s_reg.irq;
  assign general_converter_trig = s_reg.adc_trig;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic per_end;
    logic dead_ok;
    logic [CNT_W-1:0] sub;
    ppc_reg_t r;
    per_end = s_reg.cnt >= s_reg.period;
    dead_ok = s_reg.dead_cnt >= s_reg.dead;
    sub = s_reg.period >> s_reg.ctrl[CB_OS +: 2];
    if (sub == '0) sub = 14'h0001;
    r = ppc_decode(apb_req.paddr);
    s_next = s_reg;
    s_next.sync_out = 1'b0;
    s_next.irq = 1'b0;
    s_next.adc_trig = 1'b0;
    s_next.sample_req = 1'b0;
    s_next.fault_d = fault_in;
    s_next.closed_d = s_reg.ctrl[CB_CLOSED];
    if (duty_valid) s_next.duty_q = duty;

    // Time base counts 0..period, then wraps
    if (!en) begin
      s_next.cnt = '0;
      s_next.period = s_reg.period_sh;
      s_next.frame_cnt = '0;
    end else if (per_end) begin
      s_next.cnt = '0;
      // Shadow period takes effect at period end
      s_next.period = s_reg.period_sh;
      if (s_reg.frame_cnt >= s_reg.ctrl[CB_DIV +: DIV_W]) begin // Lowered divide must not stall
        s_next.frame_cnt = '0;
        s_next.irq = 1'b1;
        // Same event starts the general converter
        s_next.adc_trig = 1'b1;
      end else begin
        s_next.frame_cnt = s_reg.frame_cnt + 8'h01;
      end
    end else begin
      s_next.cnt = s_reg.cnt + 14'h0001;
    end
    // Sync input restarts the ramp; at the phase offset
    if (en && s_reg.ctrl[CB_SYNC_EN] && sync_in) s_next.cnt = s_reg.phase;
    // Fault rising edge and loop mode change also interrupt
    if ((fault_in && !s_reg.fault_d) || (s_reg.ctrl[CB_CLOSED] != s_reg.closed_d)) begin
      s_next.irq = 1'b1;
    end

    if (en && s_reg.cnt == s_reg.sthr) s_next.sync_out = 1'b1;

    // Sample request at trigger count; starts conversion
    if (en && s_reg.cnt == s_reg.strig) begin
      s_next.sample_req = 1'b1;
      s_next.os_left = (4'h1 << s_reg.ctrl[CB_OS +: 2]) - 4'h1;
      s_next.os_cnt = sub;
    end else if (en && s_reg.os_left != 4'h0) begin
      if (s_reg.os_cnt <= 14'h0001) begin
        s_next.sample_req = 1'b1;
        s_next.os_left = s_reg.os_left - 4'h1;
        s_next.os_cnt = sub;
      end else begin
        s_next.os_cnt = s_reg.os_cnt - 14'h0001;
      end
    end else if (!en) begin
      s_next.os_left = 4'h0;
    end

    // Raw edges from the four events
    if (!en) s_next.a_raw = 1'b0;
    else if (hit[1]) s_next.a_raw = 1'b0;
    else if (hit[0]) s_next.a_raw = 1'b1;
    if (!en) s_next.b_raw = 1'b0;
    else if (hit[3]) s_next.b_raw = 1'b0;
    else if (hit[2]) s_next.b_raw = 1'b1;
    // Fine position of the latest edge, in 16ths of a pulse clock
    if (hit[1]) s_next.a_fine = a_fall[FINE_W-1:0];
    else if (hit[0]) s_next.a_fine = '0;
    if (hit[3]) s_next.b_fine = b_fall[FINE_W-1:0];
    else if (hit[2]) s_next.b_fine = s_reg.ev3[FINE_W-1:0];

    // An output may rise only after the dead time with both low
    s_next.a_q = s_next.a_raw && !s_reg.b_q && (s_reg.a_q || dead_ok);
    s_next.b_q = s_next.b_raw && !s_reg.a_q && (s_reg.b_q || dead_ok);
    if (s_reg.a_q || s_reg.b_q) s_next.dead_cnt = '0;
    else if (!dead_ok) s_next.dead_cnt = s_reg.dead_cnt + 14'h0001;
    // Polarity applied at the pin; two outputs
    s_next.out_a = s_next.a_q ^ s_reg.ctrl[CB_POL_A];
    s_next.out_b = s_next.b_q ^ s_reg.ctrl[CB_POL_B];

    // APB: data set up in the setup cycle, answered in the first access cycle
    s_next.rsp.pready = apb_req.psel && !apb_req.penable;
    s_next.rsp.pslverr = apb_req.psel && !apb_req.penable && r == R_NONE;
    s_next.rsp.prdata = '0;
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      case (r)
        R_CTRL: s_next.rsp.prdata = 32'(s_reg.ctrl);
        R_PERIOD: s_next.rsp.prdata = 32'(s_reg.period_sh);
        R_EVENT1: s_next.rsp.prdata = 32'(s_reg.ev1);
        R_EVENT2: s_next.rsp.prdata = 32'(s_reg.ev2);
        R_EVENT3: s_next.rsp.prdata = 32'(s_reg.ev3);
        R_EVENT4: s_next.rsp.prdata = 32'(s_reg.ev4);
        R_PHASE: s_next.rsp.prdata = 32'(s_reg.phase);
        R_SAMPLE: s_next.rsp.prdata = 32'(s_reg.strig);
        R_SYNC_THR: s_next.rsp.prdata = 32'(s_reg.sthr);
        R_DEAD: s_next.rsp.prdata = 32'(s_reg.dead);
        R_ADJ_A: s_next.rsp.prdata = 32'(s_reg.adj_a);
        R_ADJ_B: s_next.rsp.prdata = 32'(s_reg.adj_b);
        R_DAC: s_next.rsp.prdata = 32'(s_reg.dac);
        R_STATUS: s_next.rsp.prdata = {12'h000, fe_gain, s_reg.b_q, s_reg.a_q,
                                       2'b00, s_reg.cnt};
        R_ERROR: s_next.rsp.prdata = 32'(fe_err);
        default: s_next.rsp.prdata = '0;
      endcase
    end
    if (apb_req.psel && apb_req.penable && s_reg.rsp.pready && apb_req.pwrite) begin
      case (r)
        R_CTRL: s_next.ctrl = apb_req.pwdata[CTRL_W-1:0];
        R_PERIOD: s_next.period_sh = apb_req.pwdata[CNT_W-1:0];
        R_EVENT1: s_next.ev1 = apb_req.pwdata[CNT_W-1:0];
        R_EVENT2: s_next.ev2 = apb_req.pwdata[EV_W-1:0];
        R_EVENT3: s_next.ev3 = apb_req.pwdata[EV_W-1:0];
        R_EVENT4: s_next.ev4 = apb_req.pwdata[EV_W-1:0];
        R_PHASE: s_next.phase = apb_req.pwdata[CNT_W-1:0];
        R_SAMPLE: s_next.strig = apb_req.pwdata[CNT_W-1:0];
        R_SYNC_THR: s_next.sthr = apb_req.pwdata[CNT_W-1:0];
        R_DEAD: s_next.dead = apb_req.pwdata[CNT_W-1:0];
        R_ADJ_A: s_next.adj_a = apb_req.pwdata[ADJ_W-1:0];
        R_ADJ_B: s_next.adj_b = apb_req.pwdata[ADJ_W-1:0];
        R_DAC: s_next.dac = apb_req.pwdata[DAC_W-1:0];
        default: s_next.dac = s_next.dac;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.period <= PERIOD_RST;
      s_reg.period_sh <= PERIOD_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_period_end;
    en && s_reg.cnt >= s_reg.period && !(s_reg.ctrl[CB_SYNC_EN] && sync_in);
  endsequence
  sequence seq_sync_hit;
    en && s_reg.ctrl[CB_SYNC_EN] && sync_in;
  endsequence

  chk_period_wrap: assert property (seq_period_end |=> s_reg.cnt == '0)
    else $error("counter did not wrap at period");
  chk_shadow_load: assert property (
    seq_period_end |=> s_reg.period == $past(s_reg.period_sh))
    else $error("shadow period not loaded at period end");
  chk_period_hold: assert property (
    en && !(s_reg.cnt >= s_reg.period) |=> $stable(s_reg.period))
    else $error("period changed mid cycle");
  chk_sync_reset: assert property (seq_sync_hit |=> s_reg.cnt == $past(s_reg.phase))
    else $error("sync did not load phase");
  chk_sync_out: assert property (
    en && s_reg.cnt == s_reg.sthr |=> sync_out ##1 !sync_out || $past(en && s_reg.cnt == s_reg.sthr))
    else $error("sync output missing at threshold");
  chk_dead_gap: assert property (
    $fell(s_reg.a_q) |-> !s_reg.b_q [*1] ##1 (!s_reg.b_q || s_reg.dead <= 14'h0001))
    else $error("B rose inside dead time");
  chk_no_overlap: assert property (!(s_reg.a_q && s_reg.b_q))
    else $error("A and B active together");
  chk_pol_apply: assert property (
    out_a == (s_reg.a_q ^ $past(s_reg.ctrl[CB_POL_A])))
    else $error("output A polarity wrong");
  chk_sample_req: assert property (
    en && s_reg.cnt == s_reg.strig |=> s_reg.sample_req)
    else $error("sample request missing at trigger count");
  chk_apb_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready in access phase");
  chk_trig_with_irq: assert property (general_converter_trig |-> irq_out)
    else $error("converter trigger without frame interrupt");

endmodule : ppc_channel

// ==== bench/ppc_conv_model.sv ====
// Error converter model that answers each conversion start with a fixed code
`timescale 1ns/1ps
module ppc_conv_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_start,
  output ppc_pkg::ppc_conv_t conv
);
  import ppc_pkg::*;
  // ****************************************************************
  // Conversion delay
  // ****************************************************************
  logic [1:0] wait_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 2'h0;
      conv <= '0;
    end else begin
      wait_reg <= conv_start ? 2'h3 : ((wait_reg != 2'h0) ? wait_reg - 2'h1 : 2'h0);
      conv.done <= (wait_reg == 2'h1);
      // Outside done the code toggles, so a stale capture cannot pass
      conv.code <= (wait_reg == 2'h1) ? 9'h005 : ~conv.code;
    end
  end
endmodule : ppc_conv_model

// ==== bench/power_pwm_channel_with_error_frontend_test.sv ====
// Self-checking bench of the power pulse channel
`timescale 1ns/1ps
module power_pwm_channel_with_error_frontend_test;
  import ppc_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic pclk, presetn, e;
  ppc_apb_req_t req;
  ppc_apb_rsp_t rsp;
  ppc_conv_t conv;
  logic conv_start, strobe, out_a, out_b, sync_out, irq_out, trig;
  logic sync, fault, dv;
  logic [DUTY_W-1:0] duty;
  logic [DAC_OUT_W-1:0] dac;
  logic [FINE_W-1:0] afine, bfine;
  logic [ERR_W-1:0] err;
  logic [31:0] rd;
  int fail_count, num_checks, cyc;
  int cnt [7];
  wire [6:0] mon = {trig, irq_out, strobe, conv_start, sync_out, out_b, out_a};
  ppc_channel u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .sync_in(sync), .fault_in(fault), .duty(duty), .duty_valid(dv), .conv(conv),
    .conv_start(conv_start), .filter_err(err), .filter_strobe(strobe), .dac_code(dac),
    .out_a(out_a), .out_b(out_b), .a_fine(afine), .b_fine(bfine), .sync_out(sync_out),
    .irq_out(irq_out), .general_converter_trig(trig));
  ppc_conv_model u_conv (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv(conv));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task finish_test;
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One APB transfer, held until pready; an idle cycle follows
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : apb
  // Counts active cycles over ten frames of twenty clocks
  task measure;
    cnt = '{default: 0};
    repeat (200) begin
      @(posedge pclk);
      for (int i = 0; i < 7; i++) cnt[i] += mon[i];
    end
  endtask : measure
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task run_regs;
    apb(1'b0, ADDR_PERIOD, 32'h0);
    check(rd, 32'h000000ff);
    apb(1'b0, 8'h3c, 32'h0);
    check({31'h0, e}, 32'h1);
  endtask : run_regs
  task run_wave;
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_PERIOD, 32'd19);
    apb(1'b1, ADDR_EVENT1, 32'd2);
    apb(1'b1, ADDR_EVENT2, 32'h0a0);
    apb(1'b1, ADDR_EVENT3, 32'h0c0);
    apb(1'b1, ADDR_EVENT4, 32'h120);
    apb(1'b1, ADDR_SYNC_THR, 32'd5);
    apb(1'b1, ADDR_SAMPLE, 32'd4);
    // The new period lands only after the old 256 clock frame ends
    repeat (300) @(posedge pclk);
    measure;
    check(cnt[0], 32'd80);
    check(cnt[1], 32'd60);
    check(cnt[2], 32'd10);
    check(cnt[3], 32'd10);
    check(cnt[4], 32'd10);
    check(cnt[5], 32'd10);
    check(cnt[6], 32'd10);
    check({23'h0, err}, 32'h5);
  endtask : run_wave
  task run_modes;
    apb(1'b1, ADDR_CTRL, 32'h3);
    measure;
    check(cnt[0], 32'd120);
    apb(1'b1, ADDR_CTRL, 32'h111);
    // One settling frame, so the window holds only whole oversampled frames
    repeat (20) @(posedge pclk);
    measure;
    check(cnt[3], 32'd20);
    check(cnt[5], 32'd5);
  endtask : run_modes
  // Closed loop at half duty, inverted absolute error at double step
  task run_loop;
    duty <= 24'h400000;
    dv <= 1'b1;
    apb(1'b1, ADDR_DAC, 32'h120);
    dv <= 1'b0;
    apb(1'b1, ADDR_EVENT3, 32'h0c5);
    apb(1'b1, ADDR_CTRL, 32'hb0009);
    repeat (20) @(posedge pclk);
    measure;
    check(cnt[0], 32'd90);
    check({23'h0, err}, 32'h8);
    check({22'h0, dac}, 32'h12);
    do @(posedge pclk); while (out_a !== 1'b1);
    do @(posedge pclk); while (out_a !== 1'b0);
    check({28'h0, afine}, 32'h8);
    do @(posedge pclk); while (out_b !== 1'b1);
    check({28'h0, bfine}, 32'h5);
  endtask : run_loop
  // Sync loads the phase; a fault edge raises one interrupt pulse
  task run_sync;
    apb(1'b1, ADDR_PHASE, 32'd7);
    apb(1'b1, ADDR_CTRL, 32'h41);
    sync <= 1'b1;
    @(posedge pclk);
    sync <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({18'h0, rd[13:0]}, 32'h7);
    apb(1'b1, ADDR_CTRL, 32'h0);
    fault <= 1'b1;
    repeat (2) @(posedge pclk);
    check({31'h0, irq_out}, 32'h1);
    fault <= 1'b0;
    @(posedge pclk);
    check({31'h0, irq_out}, 32'h0);
  endtask : run_sync
  // ****************************************************************
  // Clock, reset, sequence and timeout
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    req = '0;
    {sync, fault, dv} = 3'h0;
    duty = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run_regs;
    run_wave;
    run_modes;
    run_loop;
    run_sync;
    finish_test;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test;
    end
  end
endmodule : power_pwm_channel_with_error_frontend_test
